// ---- src/spsc_top.sv ----
// system clock prescaler and sleep mode control, AXI4-Lite register slave
// assumes synchronous inputs on clk; the cpu core and peripherals obey the enables
`timescale 1ns/10ps
`default_nettype none
module spsc_top #(
    parameter logic [11:0] PD_STARTUP_CYCLES = 12'h400
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        divideByEightFuse,
    input  wire logic        sleepInstr,
    input  wire logic        wakeIrq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             sysClkTick,
    output logic             cpuClkRun,
    output logic             ioClkRun,
    output logic             adcClkRun,
    output logic             oscRun,
    output logic             wakeResume
);

    typedef struct packed {
        logic [3:0]              sel;
        logic                    selLoaded;
        logic                    pce;
        logic [2:0]              pceCnt;
        logic [2:0]              mode;
        logic                    arm;
        spsc_pkg::spsc_phase_type phase;
        logic [11:0]             wakeCnt;
        logic [7:0]              divCnt;
        logic [3:0]              activeSel;
        logic                    pendValid;
        logic                    tick;
        logic                    cpuRun;
        logic                    ioRun;
        logic                    adcRun;
        logic                    oscRun;
        logic                    resume;
        logic                    awHave;
        logic [7:0]              awAddr;
        logic                    wHave;
        logic [7:0]              wData;
        logic                    wLane0;
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [7:0]              rdata;
        logic [1:0]              rresp;
    } spsc_state_type;

    spsc_state_type st_r;
    spsc_state_type st_nxt;

    // reserved selectors clamp to the slowest valid divide
    function automatic logic [7:0] divMask(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > spsc_pkg::SEL_MAX_VALID) ? spsc_pkg::SEL_MAX_VALID : sel;
        divMask = 8'((9'h001 << s) - 9'h001);
    endfunction : divMask

    function automatic logic modeValid(input logic [2:0] m);
        modeValid = (m == spsc_pkg::MODE_IDLE) || (m == spsc_pkg::MODE_ADC_NOISE) ||
                    (m == spsc_pkg::MODE_POWER_DOWN) || (m == spsc_pkg::MODE_STANDBY);
    endfunction : modeValid

    logic       doWrite;
    logic       hit;
    logic [7:0] mask;

    always_comb begin
        st_nxt  = st_r;
        mask    = divMask(st_r.activeSel);
        hit     = ((st_r.divCnt & mask) == mask);
        doWrite = st_r.awHave && st_r.wHave && !st_r.bvalid;

        // fuse is caught in the first clocked cycle after reset release
        if (!st_r.selLoaded) begin
            st_nxt.sel       = divideByEightFuse ? spsc_pkg::SEL_RESET_PROG
                                                 : spsc_pkg::SEL_RESET_UNPROG;
            st_nxt.selLoaded = 1'b1;
            st_nxt.pendValid = 1'b1;
        end

        // change-enable window countdown
        if (st_r.pce) begin
            if (st_r.pceCnt == 3'h1) begin
                st_nxt.pce = 1'b0;
            end
            st_nxt.pceCnt = st_r.pceCnt - 3'h1;
        end

        // write address and data may arrive in either order
        if (st_r.awready && s_axi_awvalid) begin
            st_nxt.awHave = 1'b1;
            st_nxt.awAddr = s_axi_awaddr;
        end
        if (st_r.wready && s_axi_wvalid) begin
            st_nxt.wHave  = 1'b1;
            st_nxt.wData  = s_axi_wdata[7:0];
            st_nxt.wLane0 = s_axi_wstrb[0];
        end

        if (doWrite) begin
            st_nxt.awHave = 1'b0;
            st_nxt.wHave  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = spsc_pkg::RESP_OKAY;
            if (st_r.awAddr == spsc_pkg::CLOCK_PRESCALE_CTRL_OFFSET) begin
                if (st_r.wLane0) begin
                    if (st_r.wData == spsc_pkg::PCE_ONLY_VALUE) begin
                        if (!st_r.pce) begin
                            st_nxt.pce    = 1'b1;
                            st_nxt.pceCnt = spsc_pkg::PCE_WINDOW_CYCLES;
                        end
                    end else if (!st_r.wData[spsc_pkg::PCE_BIT]) begin
                        if (st_r.pce && st_r.selLoaded) begin
                            st_nxt.sel = st_r.wData[spsc_pkg::SEL_LSB +: spsc_pkg::SEL_WIDTH];
                            st_nxt.pendValid = 1'b1;
                        end
                        st_nxt.pce    = 1'b0;
                        st_nxt.pceCnt = 3'h0;
                    end
                end
            end else if (st_r.awAddr == spsc_pkg::SLEEP_MODE_CTRL_OFFSET) begin
                if (st_r.wLane0) begin
                    st_nxt.arm  = st_r.wData[spsc_pkg::ARM_BIT];
                    st_nxt.mode = st_r.wData[spsc_pkg::MODE_LSB +: spsc_pkg::MODE_WIDTH];
                end
            end else begin
                st_nxt.bresp = spsc_pkg::RESP_SLVERR;
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        st_nxt.awready = !st_nxt.awHave && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.wHave && !st_nxt.bvalid;

        // read channel; unused bits read zero
        if (st_r.arready && s_axi_arvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = spsc_pkg::RESP_OKAY;
            if (s_axi_araddr == spsc_pkg::CLOCK_PRESCALE_CTRL_OFFSET) begin
                st_nxt.rdata = {st_r.pce, 3'h0, st_r.sel};
            end else if (s_axi_araddr == spsc_pkg::SLEEP_MODE_CTRL_OFFSET) begin
                st_nxt.rdata = {4'h0, st_r.mode, st_r.arm};
            end else begin
                st_nxt.rdata = 8'h00;
                st_nxt.rresp = spsc_pkg::RESP_SLVERR;
            end
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        st_nxt.arready = !st_nxt.rvalid;

        // divider: a new selector is taken only at a tick of the old one,
        // so no shortened period can reach the clock users
        st_nxt.tick = hit;
        if (hit && st_r.pendValid) begin
            st_nxt.activeSel = st_r.sel;
            st_nxt.pendValid = (st_nxt.sel != st_r.sel); // a selector written at this tick stays pending
            st_nxt.divCnt    = 8'h00;
        end else begin
            st_nxt.divCnt = st_r.divCnt + 8'h01;
        end

        // sleep sequencing; a reset needs no path here, it restarts everything
        st_nxt.resume = 1'b0;
        case (st_r.phase)
            spsc_pkg::ST_RUN: begin
                if (sleepInstr && st_r.arm && modeValid(st_r.mode)) begin
                    st_nxt.phase = spsc_pkg::ST_SLEEP;
                end
            end
            spsc_pkg::ST_SLEEP: begin
                if (wakeIrq) begin
                    st_nxt.phase = spsc_pkg::ST_WAKE;
                    if (st_r.mode == spsc_pkg::MODE_STANDBY) begin
                        st_nxt.wakeCnt = spsc_pkg::STANDBY_WAKE_CYCLES +
                                         spsc_pkg::WAKE_HALT_CYCLES;
                    end else if (st_r.mode == spsc_pkg::MODE_POWER_DOWN) begin
                        st_nxt.wakeCnt = PD_STARTUP_CYCLES + spsc_pkg::WAKE_HALT_CYCLES;
                    end else begin
                        st_nxt.wakeCnt = spsc_pkg::NO_STARTUP_CYCLES +
                                         spsc_pkg::WAKE_HALT_CYCLES;
                    end
                end
            end
            spsc_pkg::ST_WAKE: begin
                st_nxt.wakeCnt = st_r.wakeCnt - 12'h001;
                if (st_r.wakeCnt == 12'h001) begin
                    // state held by the core is not touched on this path
                    st_nxt.phase  = spsc_pkg::ST_RUN;
                    st_nxt.resume = 1'b1;
                end
            end
            default: begin
                st_nxt.phase = spsc_pkg::ST_RUN;
            end
        endcase

        // clock domain enables follow the phase and mode
        st_nxt.cpuRun = (st_nxt.phase == spsc_pkg::ST_RUN);
        st_nxt.ioRun  = (st_nxt.phase != spsc_pkg::ST_SLEEP) ||
                        (st_r.mode == spsc_pkg::MODE_IDLE);
        st_nxt.adcRun = st_nxt.ioRun || (st_r.mode == spsc_pkg::MODE_ADC_NOISE);
        st_nxt.oscRun = (st_nxt.phase != spsc_pkg::ST_SLEEP) ||
                        (st_r.mode != spsc_pkg::MODE_POWER_DOWN);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r           <= '0;
            st_r.sel       <= spsc_pkg::SEL_RESET_UNPROG;
            st_r.mode      <= spsc_pkg::SMC_RESET_VALUE[3:1];
            st_r.arm       <= spsc_pkg::SMC_RESET_VALUE[0];
            st_r.phase     <= spsc_pkg::ST_RUN;
            st_r.cpuRun    <= 1'b1;
            st_r.ioRun     <= 1'b1;
            st_r.adcRun    <= 1'b1;
            st_r.oscRun    <= 1'b1;
            st_r.awready   <= 1'b1;
            st_r.wready    <= 1'b1;
            st_r.arready   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rresp   = st_r.rresp;
    assign s_axi_rdata   = {24'h000000, st_r.rdata};
    assign sysClkTick    = st_r.tick;
    assign cpuClkRun     = st_r.cpuRun;
    assign ioClkRun      = st_r.ioRun;
    assign adcClkRun     = st_r.adcRun;
    assign oscRun        = st_r.oscRun;
    assign wakeResume    = st_r.resume;

    property p_pceWindow;
        @(posedge clk) disable iff (!resetn)
        $rose(st_r.pce) |-> (st_r.pceCnt == spsc_pkg::PCE_WINDOW_CYCLES);
    endproperty
    a_pceWindow: assert property (p_pceWindow)
        else $error("change enable window not opened at four cycles");

    property p_pceExpire;
        @(posedge clk) disable iff (!resetn)
        (st_r.pce && st_r.pceCnt == 3'h1) |=> !st_r.pce;
    endproperty
    a_pceExpire: assert property (p_pceExpire)
        else $error("change enable outlived its window");

    property p_pceNoRestart;
        @(posedge clk) disable iff (!resetn)
        (st_r.pce && st_nxt.pce) |=> (st_r.pceCnt == $past(st_r.pceCnt) - 3'h1);
    endproperty
    a_pceNoRestart: assert property (p_pceNoRestart)
        else $error("change enable window restarted");

    property p_selGuarded;
        @(posedge clk) disable iff (!resetn)
        (st_r.selLoaded && !st_r.pce) |=> $stable(st_r.sel);
    endproperty
    a_selGuarded: assert property (p_selGuarded)
        else $error("selector changed without change enable");

    property p_pceSetOnlyExact;
        @(posedge clk) disable iff (!resetn)
        $rose(st_r.pce) |-> $past(doWrite) && ($past(st_r.wData) == spsc_pkg::PCE_ONLY_VALUE);
    endproperty
    a_pceSetOnlyExact: assert property (p_pceSetOnlyExact)
        else $error("change enable set by a mixed write");

    property p_fuseLoad;
        @(posedge clk) disable iff (!resetn)
        (!st_r.selLoaded && divideByEightFuse) |=> (st_r.sel == spsc_pkg::SEL_RESET_PROG);
    endproperty
    a_fuseLoad: assert property (p_fuseLoad)
        else $error("selector did not load fuse reset value");

    property p_sleepNeedsArm;
        @(posedge clk) disable iff (!resetn)
        (st_r.phase == spsc_pkg::ST_RUN && st_nxt.phase == spsc_pkg::ST_SLEEP)
            |-> (st_r.arm && sleepInstr);
    endproperty
    a_sleepNeedsArm: assert property (p_sleepNeedsArm)
        else $error("sleep entered without arm and instruction");

    property p_idleWakeHalt;
        @(posedge clk) disable iff (!resetn)
        (st_r.phase == spsc_pkg::ST_SLEEP && wakeIrq && st_r.mode == spsc_pkg::MODE_IDLE)
            |=> !cpuClkRun [*4] ##1 (cpuClkRun && wakeResume);
    endproperty
    a_idleWakeHalt: assert property (p_idleWakeHalt)
        else $error("cpu halt after wake not four cycles");

    property p_standbyWake;
        @(posedge clk) disable iff (!resetn)
        (st_r.phase == spsc_pkg::ST_SLEEP && wakeIrq && st_r.mode == spsc_pkg::MODE_STANDBY)
            |=> oscRun ##10 wakeResume;
    endproperty
    a_standbyWake: assert property (p_standbyWake)
        else $error("standby wake not six plus four cycles");

    property p_powerDownOsc;
        @(posedge clk) disable iff (!resetn)
        (st_r.phase == spsc_pkg::ST_SLEEP && st_r.mode == spsc_pkg::MODE_POWER_DOWN)
            |-> (!oscRun && !ioClkRun && !adcClkRun && !cpuClkRun);
    endproperty
    a_powerDownOsc: assert property (p_powerDownOsc)
        else $error("clock left running in power-down");

    property p_reservedRead;
        @(posedge clk) disable iff (!resetn)
        $rose(s_axi_rvalid) |-> (s_axi_rdata[31:8] == 24'h000000) && !s_axi_rdata[6];
    endproperty
    a_reservedRead: assert property (p_reservedRead)
        else $error("unused bits read non-zero");

endmodule : spsc_top
`default_nettype wire

// ---- src/spsc_pkg.sv ----
// constants for the system clock prescaler and sleep control block
// assumes a single master clock domain and an AXI4-Lite register bus
package spsc_pkg;
    // register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] CLOCK_PRESCALE_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] SLEEP_MODE_CTRL_OFFSET     = 8'h04;
    // clock_prescale_ctrl fields
    localparam int         PCE_BIT            = 7;
    localparam int         SEL_LSB            = 0;
    localparam int         SEL_WIDTH          = 4;
    localparam logic [7:0] PCE_ONLY_VALUE     = 8'h80;
    localparam logic [3:0] SEL_RESET_UNPROG   = 4'h0;
    localparam logic [3:0] SEL_RESET_PROG     = 4'h3;
    localparam logic [3:0] SEL_MAX_VALID      = 4'h8;
    localparam logic [2:0] PCE_WINDOW_CYCLES  = 3'h4;
    // sleep_mode_ctrl fields
    localparam int         ARM_BIT            = 0;
    localparam int         MODE_LSB           = 1;
    localparam int         MODE_WIDTH         = 3;
    localparam logic [7:0] SMC_RESET_VALUE    = 8'h00;
    localparam logic [2:0] MODE_IDLE          = 3'h0;
    localparam logic [2:0] MODE_ADC_NOISE     = 3'h1;
    localparam logic [2:0] MODE_POWER_DOWN    = 3'h2;
    localparam logic [2:0] MODE_STANDBY       = 3'h6;
    // wake timing in master clock cycles
    localparam logic [11:0] WAKE_HALT_CYCLES    = 12'h004;
    localparam logic [11:0] STANDBY_WAKE_CYCLES = 12'h006;
    localparam logic [11:0] NO_STARTUP_CYCLES   = 12'h000;
    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} spsc_phase_type;
endpackage : spsc_pkg

// ---- dv/tb_top.sv ----
// bench for spsc_top: prescaler change window, divide ratios, sleep entry and wake timing
// assumes spsc_pkg and spsc_top are compiled first; one 25 MHz clock, bready/rready held high
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [11:0] PD_START = 12'h008;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        fuse = 1'b1;
    logic        slp = 1'b0;
    logic        wake = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic        tick, cpuRun, ioRun, adcRun, oscRun, resume, slept;
    logic [7:0]  d;
    integer      seed;
    int          num_errors, tests_run, modelSel, modelSmc, p, n, m;

    spsc_top #(.PD_STARTUP_CYCLES(PD_START)) u_spsc_top (
        .clk(clk), .resetn(resetn), .divideByEightFuse(fuse), .sleepInstr(slp), .wakeIrq(wake),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .sysClkTick(tick), .cpuClkRun(cpuRun), .ioClkRun(ioRun), .adcClkRun(adcRun),
        .oscRun(oscRun), .wakeResume(resume));

    initial forever #20 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("errors %0d comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // valid drops at its own handshake edge, so a following call may raise it again at once
    task automatic axiWrite(input logic [7:0] a, input logic [7:0] dat, output logic [1:0] r);
        bit awOk;
        bit wOk;
        int k;
        awOk = 1'b0;
        wOk = 1'b0;
        k = 0;
        awaddr <= a;
        wdata <= {24'h0, dat};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (awvalid && awready) begin
                awOk = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wOk = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(awOk && wOk) && k < 50);
        do begin
            @(posedge clk);
            k++;
        end while (!bvalid && k < 100);
        r = bresp;
        if (k >= 100) check(32'h1, 32'h0);
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] r);
        int k;
        k = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (!arready && k < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge clk);
            k++;
        end while (!rvalid && k < 100);
        dat = rdata;
        r = rresp;
        if (k >= 100) check(32'h1, 32'h0);
    endtask : axiRead

    task automatic doReset(input logic f);
        resetn <= 1'b0;
        fuse <= f;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        modelSel = f ? 3 : 0;
        modelSmc = 0;
    endtask : doReset

    // skips two ticks so a pending divide change has settled before measuring
    task automatic tickPeriod(output int per);
        int k;
        k = 0;
        repeat (2) begin
            do begin
                @(posedge clk);
                k++;
            end while (!tick && k < 1200);
        end
        per = 0;
        do begin
            @(posedge clk);
            per++;
        end while (!tick && per < 600);
    endtask : tickPeriod

    task automatic pulseSleep();
        slp <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulseSleep

    initial begin
        #2400000;
        num_errors++;
        complete_run();
    end

    initial begin
        seed = 56672;
        doReset(1'b1);
        axiRead(8'h00, rd, resp);
        check(rd, modelSel);
        tickPeriod(p);
        check(p, 1 << modelSel);
        axiWrite(8'h00, 8'h05, resp);
        axiWrite(8'h00, 8'h81, resp);
        axiWrite(8'h00, 8'h05, resp);
        axiRead(8'h00, rd, resp);
        check(rd, modelSel);
        axiWrite(8'h00, 8'h80, resp);
        repeat (6) @(posedge clk);
        axiWrite(8'h00, 8'h05, resp);
        axiWrite(8'h00, 8'h80, resp);
        axiWrite(8'h00, 8'h80, resp);
        axiWrite(8'h00, 8'h05, resp);
        axiRead(8'h00, rd, resp);
        check(rd, modelSel);
        for (int s = 0; s < 16; s++) begin
            d = {1'b0, 3'($random(seed)), 4'(s)};
            axiWrite(8'h00, 8'h80, resp);
            axiWrite(8'h00, d, resp);
            check(resp, 2'h0);
            modelSel = s;
            axiWrite(8'h00, d ^ 8'h01, resp);
            axiRead(8'h00, rd, resp);
            check(rd, modelSel);
            tickPeriod(p);
            check(p, 1 << ((s > 8) ? 8 : s));
        end
        axiRead(8'h08, rd, resp);
        check(rd, 32'h0);
        check(resp, 2'h2);
        axiWrite(8'h0C, 8'hFF, resp);
        check(resp, 2'h2);
        for (int i = 0; i < 9; i++) begin
            m = i % 8;
            d = {4'($random(seed)), 3'(m), 1'(i < 8)};
            axiWrite(8'h04, d, resp);
            modelSmc = d & 8'h0F;
            axiRead(8'h04, rd, resp);
            check(rd, modelSmc);
            slept = (i < 8) && (m inside {0, 1, 2, 6});
            pulseSleep();
            check(cpuRun, !slept);
            if (slept) begin
                check({ioRun, adcRun, oscRun}, {m == 0, m <= 1, m != 2});
                wake <= 1'b1;
                @(posedge clk);
                wake <= 1'b0;
                n = 0;
                do begin
                    @(posedge clk);
                    n++;
                end while (!resume && n < 2000);
                check(n, 1 + ((m == 2) ? PD_START + 4 : (m == 6) ? 10 : 4));
                @(posedge clk);
                check(cpuRun, 1'b1);
            end
            axiWrite(8'h04, 8'h00, resp);
        end
        axiWrite(8'h04, 8'h05, resp);
        pulseSleep();
        check(cpuRun, 1'b0);
        doReset(1'b0);
        check(cpuRun, 1'b1);
        axiRead(8'h00, rd, resp);
        check(rd, modelSel);
        axiRead(8'h04, rd, resp);
        check(rd, modelSmc);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
